/* logic/cold_load_pickup.sv */
/*
 * Cold load pickup supervisor: detects warm-to-cold transitions, times the
 * load-off delay, raises cold_load_active, and releases it after inrush has
 * settled or the maximum-block time runs out.
 * Assumes pin-level inputs (breaker_open, undercurrent, block_ext) arrive
 * asynchronously; the current sample, config and internal blocks are in the
 * clk domain.
 */
//
// Notes on behaviour
// R1 - cold detected by breaker, undercurrent, both, or either; mode selectable
// R2 - warm-to-cold transition starts configurable load-off timer before declaring cold
// R3 - load-off expiry asserts cold_load_active for use by other elements
// R4 - end of cold condition starts inrush detector tracking rise and fall
// R5 - inrush present when load current exceeds the inrush threshold
// R6 - inrush finished when current falls to 90 percent of threshold
// R7 - settle timer starts after inrush ends; output drops at its expiry, or earlier on max-block expiry or a block
// R8 - max-block timer runs parallel to inrush detector; expiry drops the output
// R9 - selected external or internal block keeps the output inactive
// R10 - running auto-reclose blocks the function on variants that have it
// R11 - only a status output is produced; no trip or arming output exists
// R12 - max-block stops once current stays below 0.9 threshold for settle time
// R13 - timers count clock ticks from presets; reset clears them, output inactive
`timescale 1ns/1ps
`default_nettype none

module cold_load_pickup (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire cold_load_pkg::cold_in_t     pins,
	input  wire cold_load_pkg::cold_cfg_t    cfg,
	output var  logic                        cold_load_active,
	output var  cold_load_pkg::cold_status_t status
);

	////////////////////////////////////////////////////////////////////////
	// functions

	// cold decision for a mode; used by the detector only, its check decodes AND mode itself
	function automatic logic cold_of(input cold_load_pkg::detect_mode_t m,
		input logic brk, input logic uc);
		logic r;
		r = 1'b0;
		case (m)
			cold_load_pkg::MODE_BREAKER:  r = brk;
			cold_load_pkg::MODE_UNDERCUR: r = uc;
			cold_load_pkg::MODE_AND:      r = brk & uc;
			default:                      r = brk | uc;
		endcase
		return r;
	endfunction : cold_of

	// scaled threshold, widened so the product cannot wrap
	function automatic logic [cold_load_pkg::CUR_W+7:0] scale(input logic [cold_load_pkg::CUR_W-1:0] v,
		input int unsigned k);
		return (cold_load_pkg::CUR_W+8)'(v) * (cold_load_pkg::CUR_W+8)'(k);
	endfunction : scale

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change taken when stages two and three agree

	logic [2:0] brk_sync_r;
	logic [2:0] uc_sync_r;
	logic [2:0] blk_sync_r;
	logic       brk_r;
	logic       uc_r;
	logic       blk_ext_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			brk_sync_r <= 3'h0;
			uc_sync_r  <= 3'h0;
			blk_sync_r <= 3'h0;
		end
		else
		begin
			brk_sync_r <= {brk_sync_r[1:0], pins.breaker_open};
			uc_sync_r  <= {uc_sync_r[1:0], pins.undercurrent};
			blk_sync_r <= {blk_sync_r[1:0], pins.block_ext};
		end
	end

	// filtered levels only move when the last two stages match
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			brk_r     <= 1'b0;
			uc_r      <= 1'b0;
			blk_ext_r <= 1'b0;
		end
		else
		begin
			if (brk_sync_r[2] == brk_sync_r[1])
				brk_r <= brk_sync_r[2];
			if (uc_sync_r[2] == uc_sync_r[1])
				uc_r <= uc_sync_r[2];
			if (blk_sync_r[2] == blk_sync_r[1])
				blk_ext_r <= blk_sync_r[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// condition decode

	logic cold_now;
	logic blocked;
	logic above_thr;
	logic below_drop;

	assign cold_now = cold_of(cfg.breaker_position_mode, brk_r, uc_r); // [R1]
	assign blocked  = (cfg.sel_block_ext & blk_ext_r)
		| (cfg.sel_block_int & pins.block_int)                        // [R9]
		| (cfg.has_auto_reclose & pins.auto_reclose_running);         // [R10]
	// compare in hundredths to avoid a divider: I*100 > thr*100
	assign above_thr  = scale(pins.load_current, cold_load_pkg::DROP_DEN)
		> scale(cfg.inrush_threshold, cold_load_pkg::DROP_DEN);       // [R5]
	assign below_drop = scale(pins.load_current, cold_load_pkg::DROP_DEN)
		<= scale(cfg.inrush_threshold, cold_load_pkg::DROP_NUM);      // [R6]

	////////////////////////////////////////////////////////////////////////
	// state machine and phase timer

	cold_load_pkg::cold_state_t state_r;
	cold_load_pkg::cold_state_t state_nxt;
	logic [cold_load_pkg::TIMER_W-1:0] tmr_r;
	logic [cold_load_pkg::TIMER_W-1:0] tmr_nxt;
	logic [cold_load_pkg::TIMER_W-1:0] maxblk_r;
	logic [cold_load_pkg::TIMER_W-1:0] maxblk_nxt;
	logic                              maxblk_run_r;
	logic                              maxblk_run_nxt;
	logic                              inrush_r;
	logic                              inrush_nxt;

	// one timer reused per phase; preset loaded on entry, counts down to zero
	always_comb
	begin
		state_nxt      = state_r;
		tmr_nxt        = (tmr_r != cold_load_pkg::TIMER_ZERO) ? tmr_r - cold_load_pkg::TIMER_ONE : tmr_r; // [R13]
		maxblk_nxt     = (maxblk_run_r && maxblk_r != cold_load_pkg::TIMER_ZERO)
			? maxblk_r - cold_load_pkg::TIMER_ONE : maxblk_r;
		maxblk_run_nxt = maxblk_run_r;
		inrush_nxt     = inrush_r;
		case (state_r)
			cold_load_pkg::ST_WARM:
			begin
				if (cold_now)
				begin
					state_nxt = cold_load_pkg::ST_LOADOFF; // [R2]
					tmr_nxt   = cfg.t_load_off;
				end
			end
			cold_load_pkg::ST_LOADOFF:
			begin
				if (!cold_now)
					state_nxt = cold_load_pkg::ST_WARM;
				else if (tmr_r == cold_load_pkg::TIMER_ZERO)
					state_nxt = cold_load_pkg::ST_COLD;    // [R3]
			end
			cold_load_pkg::ST_COLD:
			begin
				if (!cold_now)
				begin
					state_nxt      = cold_load_pkg::ST_INRUSH; // [R4]
					maxblk_nxt     = cfg.t_max_block;          // [R8]
					maxblk_run_nxt = 1'b1;
					inrush_nxt     = 1'b0;
				end
			end
			cold_load_pkg::ST_INRUSH:
			begin
				// rise then fall of inrush; no inrush at all also lands in settle
				if (above_thr)
					inrush_nxt = 1'b1;                         // [R5]
				else if (below_drop)
				begin
					inrush_nxt = 1'b0;
					state_nxt  = cold_load_pkg::ST_SETTLE;     // [R6] [R7]
					tmr_nxt    = cfg.t_settle;
				end
			end
			default:
			begin
				if (!below_drop)
					state_nxt = cold_load_pkg::ST_INRUSH;      // current rose again
				else if (tmr_r == cold_load_pkg::TIMER_ZERO)
				begin
					state_nxt      = cold_load_pkg::ST_WARM;   // [R7]
					maxblk_run_nxt = 1'b0;                     // [R12]
				end
			end
		endcase
		// max-block expiry or a block ends the episode in any post-cold phase
		if ((state_r == cold_load_pkg::ST_INRUSH || state_r == cold_load_pkg::ST_SETTLE)
			&& maxblk_run_r && maxblk_r == cold_load_pkg::TIMER_ZERO)
		begin
			state_nxt      = cold_load_pkg::ST_WARM;           // [R8]
			maxblk_run_nxt = 1'b0;
		end
		if (blocked)
		begin
			state_nxt      = cold_load_pkg::ST_WARM;           // [R9] [R10]
			maxblk_run_nxt = 1'b0;
			inrush_nxt     = 1'b0;
		end
	end

	// state and timers; synchronous reset behaviour folded into async clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r      <= cold_load_pkg::ST_WARM;            // [R13]
			tmr_r        <= cold_load_pkg::TIMER_ZERO;
			maxblk_r     <= cold_load_pkg::TIMER_ZERO;
			maxblk_run_r <= 1'b0;
			inrush_r     <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			tmr_r        <= tmr_nxt;
			maxblk_r     <= maxblk_nxt;
			maxblk_run_r <= maxblk_run_nxt;
			inrush_r     <= inrush_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs: status only, nothing here can trip

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cold_load_active <= 1'b0;                          // [R13]
			status           <= '0;
		end
		else
		begin
			cold_load_active <= (state_nxt == cold_load_pkg::ST_COLD
				|| state_nxt == cold_load_pkg::ST_INRUSH
				|| state_nxt == cold_load_pkg::ST_SETTLE);         // [R3] [R11]
			status.cold_condition    <= cold_now;
			status.inrush_present    <= inrush_nxt;
			status.load_off_running  <= (state_nxt == cold_load_pkg::ST_LOADOFF);
			status.settle_running    <= (state_nxt == cold_load_pkg::ST_SETTLE);
			status.max_block_running <= maxblk_run_nxt;
			status.blocked           <= blocked;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_cold_stable;
		state_r == cold_load_pkg::ST_LOADOFF && cold_now && tmr_r == cold_load_pkg::TIMER_ZERO && !blocked;
	endsequence

	sequence s_enter_inrush;
		state_r == cold_load_pkg::ST_COLD && !cold_now && !blocked;
	endsequence

	chk_mode_decode: assert property (@(posedge clk) disable iff (rst) // [R1]
		cfg.breaker_position_mode == cold_load_pkg::MODE_AND |-> cold_now == (brk_r & uc_r))
		else $error("cold decode wrong in AND mode");

	chk_loadoff_start: assert property (@(posedge clk) disable iff (rst) // [R2]
		state_r == cold_load_pkg::ST_WARM && cold_now && !blocked |=> state_r == cold_load_pkg::ST_LOADOFF && tmr_r == $past(cfg.t_load_off))
		else $error("load-off timer not started");

	chk_enable_rise: assert property (@(posedge clk) disable iff (rst) // [R3]
		s_cold_stable |=> cold_load_active)
		else $error("enable not raised at load-off expiry");

	chk_inrush_start: assert property (@(posedge clk) disable iff (rst) // [R4] [R8]
		s_enter_inrush |=> state_r == cold_load_pkg::ST_INRUSH && maxblk_run_r && cold_load_active)
		else $error("inrush phase or max-block not started");

	chk_inrush_flag: assert property (@(posedge clk) disable iff (rst) // [R5]
		state_r == cold_load_pkg::ST_INRUSH && above_thr && !blocked |=> status.inrush_present)
		else $error("inrush not flagged above threshold");

	chk_settle_hold: assert property (@(posedge clk) disable iff (rst) // [R7]
		$fell(cold_load_active) |-> $past(blocked) || $past(state_r) != cold_load_pkg::ST_SETTLE || $past(tmr_r) == cold_load_pkg::TIMER_ZERO
		|| $past(maxblk_r) == cold_load_pkg::TIMER_ZERO)
		else $error("enable dropped before settle expiry");

	chk_block_quiet: assert property (@(posedge clk) disable iff (rst) // [R9] [R10]
		blocked |=> !cold_load_active)
		else $error("enable active while blocked");

	chk_maxblk_end: assert property (@(posedge clk) disable iff (rst) // [R8] [R12]
		maxblk_run_r && maxblk_r == cold_load_pkg::TIMER_ZERO |=> !maxblk_run_r && !cold_load_active)
		else $error("max-block expiry did not release");

endmodule : cold_load_pickup

`default_nettype wire

/* logic/cold_load_pkg.sv */
/*
 * Package for the cold load pickup supervisor: mode encoding, state encoding,
 * input/config/status structs and timer widths.
 * Assumes a single 40 MHz clock domain; presets are given in clock ticks.
 */
`default_nettype none

package cold_load_pkg;

	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned TIMER_W     = 32;
	localparam int unsigned CUR_W       = 16;
	// drop-out ratio of the inrush detector: 90 %, as numerator over 100
	localparam int unsigned DROP_NUM    = 90;
	localparam int unsigned DROP_DEN    = 100;
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h0000_0000;
	localparam logic [TIMER_W-1:0] TIMER_ONE  = 32'h0000_0001;

	// cold condition detection modes
	typedef enum logic [1:0] {
		MODE_BREAKER = 2'h0,
		MODE_UNDERCUR = 2'h1,
		MODE_AND     = 2'h2,
		MODE_OR      = 2'h3
	} detect_mode_t;

	typedef enum logic [2:0] {
		ST_WARM    = 3'h0,
		ST_LOADOFF = 3'h1,
		ST_COLD    = 3'h2,
		ST_INRUSH  = 3'h3,
		ST_SETTLE  = 3'h4
	} cold_state_t;

	// live inputs from breaker contacts, comparators, block sources and auto-reclose
	typedef struct packed {
		logic              breaker_open;
		logic              undercurrent;
		logic [CUR_W-1:0]  load_current;
		logic              block_ext;
		logic              block_int;
		logic              auto_reclose_running;
	} cold_in_t;

	// user configuration
	typedef struct packed {
		detect_mode_t      breaker_position_mode;
		logic              sel_block_ext;
		logic              sel_block_int;
		logic              has_auto_reclose;
		logic [CUR_W-1:0]  inrush_threshold;
		logic [TIMER_W-1:0] t_load_off;
		logic [TIMER_W-1:0] t_settle;
		logic [TIMER_W-1:0] t_max_block;
	} cold_cfg_t;

	typedef struct packed {
		logic              cold_condition;
		logic              inrush_present;
		logic              load_off_running;
		logic              settle_running;
		logic              max_block_running;
		logic              blocked;
	} cold_status_t;

endpackage : cold_load_pkg

`default_nettype wire

/* dv/breaker_meter.sv */
/*
 * Far-side model: breaker auxiliary contacts and a current comparator.
 * Assumes the bench drives open_cmd and amps on rising clk edges.
 */
`timescale 1ns/1ps
`default_nettype none

module breaker_meter #(
	parameter int unsigned LAG      = 2,
	parameter logic [15:0] UC_LEVEL = 16'h0010
) (
	input  wire logic        clk,
	input  wire logic        open_cmd,
	input  wire logic [15:0] amps,
	output logic             breaker_open,
	output logic             undercurrent,
	output logic [15:0]      load_current
);
	logic [7:0] lag_r = 8'h00;
	logic       pos_r = 1'b0;

	////////////////////////////////////////////////////////////////
	// contacts settle a few cycles late, so the block never sees an ideal edge
	always_ff @(posedge clk)
	begin
		lag_r <= (pos_r == open_cmd) ? 8'h00 : lag_r + 8'h01;
		if (lag_r >= LAG[7:0])
			pos_r <= open_cmd;
	end

	// comparator output is plain level: below the preset means no current
	assign breaker_open = pos_r;
	assign undercurrent = amps < UC_LEVEL;
	assign load_current = amps;
endmodule : breaker_meter

`default_nettype wire

/* dv/testbench.sv */
/*
 * Self-checking bench for the cold load pickup supervisor.
 * Assumes the breaker_meter model and a 40 MHz clock; presets are small tick counts.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
	$display("CHECK FAILED at %0t: %s", $time, msg); end end

module testbench;
	localparam int A = 6, CC = 5, IR = 4, LO = 3, SE = 2, MB = 1, BL = 0;
	logic                     clk;
	logic                     rst;
	logic                     open_cmd;
	logic [15:0]              amps;
	logic                     blk_ext, blk_int, reclose_run;
	logic                     exp_cold;
	logic                     brk, uc;
	logic [15:0]              cur;
	cold_load_pkg::cold_in_t  pins;
	cold_load_pkg::cold_cfg_t cfg;
	logic                     active;
	cold_load_pkg::cold_status_t status;
	wire  [6:0]               obs = {active, status};
	int                       miscompares = 0;
	int                       check_count = 0;

	assign pins = {brk, uc, cur, blk_ext, blk_int, reclose_run};

	breaker_meter u_breaker_meter (.clk(clk), .open_cmd(open_cmd), .amps(amps), .breaker_open(brk),
		.undercurrent(uc), .load_current(cur));
	cold_load_pickup u_cold_load_pickup (.clk(clk), .rst(rst), .pins(pins), .cfg(cfg),
		.cold_load_active(active), .status(status));

	////////////////////////////////////////////////////////////////
	// clock and watchdog; the run needs well under 2000 cycles
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		#(25 * 5000);
		miscompares++;
		stop_test();
	end

	task stop_test();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	// sample at falling edges, after the registered outputs have landed
	// first look is a falling edge, never the edge that launched the change
	task wt(input int b, input logic v, input int lim, input string msg);
		@(negedge clk);
		for (int i = 0; i < lim && obs[b] !== v; i++)
			@(negedge clk);
		`CHK(obs[b], v, msg)
	endtask : wt

	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task drive(input logic op, input logic [15:0] a);
		@(posedge clk);
		open_cmd <= op;
		amps     <= a;
	endtask : drive

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		rst = 1'b1; open_cmd = 1'b0; amps = 16'h0080;
		blk_ext = 1'b0; blk_int = 1'b0; reclose_run = 1'b0; exp_cold = 1'b0;
		cfg = {cold_load_pkg::MODE_BREAKER, 1'b1, 1'b1, 1'b0, 16'h0100,
			32'h0000_0005, 32'h0000_0004, 32'h0000_0028};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		`CHK(obs, 7'h00, "outputs after reset")
		// full episode: load-off, inrush, 90 percent boundary, settle
		drive(1'b1, 16'h0080);
		wt(LO, 1'b1, 20, "load-off timer start");
		cyc(5);
		`CHK(obs[A], 1'b0, "enable before load-off expiry")
		wt(A, 1'b1, 3, "enable on load-off expiry");
		`CHK(obs[CC], 1'b1, "cold condition flagged")
		drive(1'b0, 16'h0200);
		wt(MB, 1'b1, 20, "max-block start when cold ends");
		`CHK(obs[CC], 1'b0, "cold condition cleared")
		wt(IR, 1'b1, 5, "inrush above threshold");
		drive(1'b0, 16'h00E7);
		cyc(10);
		`CHK(obs[SE], 1'b0, "no settle just above 90 percent")
		drive(1'b0, 16'h00E6);
		wt(SE, 1'b1, 4, "settle at 90 percent");
		cyc(3);
		`CHK(obs[A], 1'b1, "enable held during settle")
		wt(A, 1'b0, 4, "enable drops after settle");
		`CHK(obs[MB], 1'b0, "max-block stopped by settle")
		// prolonged inrush ends on the max-block timer
		@(posedge clk) cfg.breaker_position_mode <= cold_load_pkg::MODE_OR;
		drive(1'b1, 16'h0080);
		wt(A, 1'b1, 30, "enable in or mode");
		drive(1'b0, 16'h0200);
		wt(MB, 1'b1, 20, "max-block running");
		cyc(38);
		`CHK(obs[A], 1'b1, "enable before max-block expiry")
		wt(A, 1'b0, 6, "enable drops on max-block expiry");
		drive(1'b0, 16'h0080);
		cyc(30);
		// every detection mode against breaker-only, current-only and both
		for (int m = 0; m < 4; m++)
			for (int c = 1; c < 4; c++)
			begin
				@(posedge clk) cfg.breaker_position_mode <= cold_load_pkg::detect_mode_t'(m[1:0]);
				drive(c[0], c[1] ? 16'h0000 : 16'h0080);
				exp_cold = (m == 0) ? c[0] : (m == 1) ? c[1] : (m == 2) ? (c == 3) : 1'b1;
				// both pin paths are in load-off ten cycles on, so a zero here means no detection
				cyc(10);
				`CHK(obs[LO], exp_cold, "cold detection per mode")
				drive(1'b0, 16'h0080);
				cyc(30);
			end
		// selected blocks and auto-reclose keep the enable off
		@(posedge clk);
		cfg.breaker_position_mode <= cold_load_pkg::MODE_BREAKER;
		blk_ext <= 1'b1;
		drive(1'b1, 16'h0080);
		cyc(20);
		`CHK(obs[BL], 1'b1, "external block seen")
		`CHK(obs[A], 1'b0, "no enable while blocked")
		@(posedge clk) blk_ext <= 1'b0;
		wt(A, 1'b1, 25, "enable after block release");
		@(posedge clk) blk_int <= 1'b1;
		wt(A, 1'b0, 3, "internal block drops enable");
		@(posedge clk) blk_int <= 1'b0;
		reclose_run <= 1'b1;
		wt(A, 1'b1, 25, "auto-reclose ignored without option");
		@(posedge clk) cfg.has_auto_reclose <= 1'b1;
		wt(A, 1'b0, 3, "auto-reclose blocks enable");
		// a block source that is not selected must not hold the enable off
		@(posedge clk);
		reclose_run       <= 1'b0;
		cfg.sel_block_int <= 1'b0;
		blk_int           <= 1'b1;
		wt(A, 1'b1, 25, "deselected internal block ignored");
		stop_test();
	end
endmodule : testbench

`default_nettype wire
